// File: bench/cpd_chk_sva.sv
`timescale 1ns/1ps
module cpd_chk #(
    parameter int CNT_W = 16
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic run_en,
    input wire logic start_at_crest,
    input wire cpd_pkg::cpd_mode_t transfer_timing_select,
    input wire logic [CNT_W-1:0] period_register,
    input wire logic [CNT_W-1:0] dead_time,
    input wire logic buf_wr,
    input wire logic [CNT_W-1:0] buf_wdata,
    input wire logic pos_phase_q,
    input wire logic neg_phase_q,
    input wire logic [CNT_W-1:0] duty_compare_register_q,
    input wire logic [CNT_W-1:0] duty_temporary_register_q,
    input wire logic [CNT_W-1:0] count_q,
    input wire logic in_window_q,
    input wire logic extreme_unsupported_q
);
    logic [31:0] gap_q;
    logic [1:0] age_q;
    ////////////////////////////////////////////////////////////////////////////
    // Length of the both-off run before each turn-on
    always_ff @(posedge sys_clk) begin
        if (!reset_n || pos_phase_q || neg_phase_q) begin
            gap_q <= 32'h0000_0000;
        end else if (gap_q != 32'hFFFF_FFFF) begin
            gap_q <= gap_q + 32'h0000_0001;
        end
    end
    // Cycles since run start; the reload at start has no gap, so skip it
    always_ff @(posedge sys_clk) begin
        if (!reset_n || !run_en) begin
            age_q <= 2'h0;
        end else if (age_q != 2'h3) begin
            age_q <= age_q + 2'h1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    no_overlap_a: assert property (!(pos_phase_q && neg_phase_q))
        else $error("both phases on");
    dead_gap_a: assert property (($rose(pos_phase_q) || $rose(neg_phase_q)) && age_q == 2'h3
        |-> gap_q > 32'(dead_time)) else $error("dead-time gap short");
    zero_hold_a: assert property ($rose(pos_phase_q) && age_q == 2'h3 && !extreme_unsupported_q
        |-> duty_compare_register_q != period_register) else $error("pos on at 0 percent");
    full_hold_a: assert property ($rose(neg_phase_q) && age_q == 2'h3 && !extreme_unsupported_q
        |-> duty_compare_register_q != '0) else $error("neg on at 100 percent");
    xfer_edge_a: assert property (run_en && $past(run_en) && $changed(duty_compare_register_q)
        |-> $fell(in_window_q)) else $error("transfer not at window end");
    trough_only_a: assert property (run_en && $past(run_en)
        && $changed(duty_compare_register_q)
        && transfer_timing_select == cpd_pkg::CPD_MODE_TROUGH
        |-> count_q < (period_register >> 1)) else $error("transfer away from trough");
    temp_hold_a: assert property (run_en && $past(run_en)
        && $changed(duty_temporary_register_q) |-> !in_window_q) else $error("temp moved in window");
    temp_write_a: assert property (buf_wr && run_en && count_q > dead_time + 1'b1
        && count_q + dead_time + 1'b1 < period_register
        |=> duty_temporary_register_q == $past(buf_wdata)) else $error("open write not taken");
    unsup_flag_a: assert property ((run_en && !start_at_crest
        && transfer_timing_select == cpd_pkg::CPD_MODE_CREST
        && duty_compare_register_q == period_register)[*3] |-> extreme_unsupported_q)
        else $error("unsupported case not flagged");
    crest_zero_a: assert property ((run_en && start_at_crest
        && transfer_timing_select == cpd_pkg::CPD_MODE_BOTH
        && duty_compare_register_q == period_register)[*3] |-> !extreme_unsupported_q)
        else $error("crest 0 percent flagged");
    // Main scenarios
    zero_c: cover property (run_en && duty_compare_register_q == period_register);
    full_c: cover property (run_en && duty_compare_register_q == '0 && pos_phase_q);
    defer_c: cover property (buf_wr && in_window_q);
endmodule : cpd_chk

// File: bench/cpd_stage.sv
`timescale 1ns/1ps
module cpd_stage (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic pos_gate,
    input wire logic neg_gate,
    output logic fault_q
);
    // Shoot-through would short the rail, so it is latched, cleared only by reset
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            fault_q <= 1'b0;
        end else if (pos_gate && neg_gate) begin
            fault_q <= 1'b1;
        end
    end
endmodule : cpd_stage

// File: bench/cpd_top_bench.sv
`timescale 1ns/1ps
module cpd_top_bench;
    localparam int PER = 20;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic run_en = 1'b0;
    logic crest = 1'b0;
    cpd_pkg::cpd_mode_t mode = cpd_pkg::CPD_MODE_TROUGH;
    logic buf_wr = 1'b0;
    logic [15:0] wdata = 16'h0000;
    logic pos, neg, inwin, unsup, fault;
    logic [15:0] dcr, tmp, cnt;
    int mismatches = 0;
    int checked = 0;
    ////////////////////////////////////////////////////////////////////////////
    // Period 20, dead time 3: windows are count 0..3 and 17..20
    cpd_top #(.CNT_W(16)) cpd_top_i (.sys_clk(sys_clk), .reset_n(reset_n), .run_en(run_en),
        .start_at_crest(crest), .transfer_timing_select(mode), .period_register(16'h0014),
        .dead_time(16'h0003), .buf_wr(buf_wr), .buf_wdata(wdata), .pos_phase_q(pos),
        .neg_phase_q(neg), .duty_compare_register_q(dcr), .duty_temporary_register_q(tmp),
        .count_q(cnt), .in_window_q(inwin), .extreme_unsupported_q(unsup));
    cpd_stage cpd_stage_i (.sys_clk(sys_clk), .reset_n(reset_n), .pos_gate(pos),
        .neg_gate(neg), .fault_q(fault));
    always #2.5 sys_clk = ~sys_clk;
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Inputs move on the falling edge only
    task automatic step(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : step
    task automatic until_cnt(input logic [15:0] v);
        for (int i = 0; i < 100 && cnt !== v; i++) begin
            step(1);
        end
    endtask : until_cnt
    task automatic until_lvl(input logic p, input logic n);
        for (int i = 0; i < 200 && (pos !== p || neg !== n); i++) begin
            step(1);
        end
    endtask : until_lvl
    task automatic wr(input logic [15:0] d);
        buf_wr = 1'b1;
        wdata = d;
        step(1);
        buf_wr = 1'b0;
    endtask : wr
    // Count 10 is clear of both windows
    task automatic wr_mid(input logic [15:0] d);
        until_cnt(16'h000A);
        wr(d);
    endtask : wr_mid
    task automatic flag_case(cpd_pkg::cpd_mode_t m, logic c, logic [15:0] d, logic e);
        run_en = 1'b0;
        mode = m;
        crest = c;
        step(3);
        run_en = 1'b1;
        wr_mid(d);
        step(4 * PER);
        chk("unsupported flag", {15'h0000, e}, {15'h0000, unsup});
    endtask : flag_case
    // Counts off-level cycles over one full period
    task automatic hold(input logic p, input logic n);
        logic [15:0] bad;
        bad = 16'h0000;
        repeat (2 * PER) begin
            step(1);
            if (pos !== p || neg !== n) bad++;
        end
        chk("level faults", 16'h0000, bad);
    endtask : hold
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_write;
        flag_case(cpd_pkg::CPD_MODE_TROUGH, 1'b0, 16'h0000, 1'b0);
        wr_mid(16'h0008);
        chk("temp open write", 16'h0008, tmp);
        until_cnt(16'h0014);
        wr(16'h000C);
        chk("temp window hold", 16'h0008, tmp);
        until_lvl(pos, neg);
        for (int i = 0; i < 20 && inwin !== 1'b0; i++) begin
            step(1);
        end
        chk("temp window end", 16'h000C, tmp);
        // The 8 was written on the down slope, so the trough already moved it
        chk("no crest transfer", 16'h0008, dcr);
        until_cnt(16'h0000);
        for (int i = 0; i < 20 && inwin !== 1'b0; i++) begin
            step(1);
        end
        chk("trough transfer", 16'h000C, dcr);
        $display("t_write done");
    endtask : t_write
    task automatic t_zero;
        flag_case(cpd_pkg::CPD_MODE_BOTH, 1'b1, 16'h000A, 1'b0);
        wr_mid(16'h0014);
        until_lvl(1'b0, 1'b0);
        until_lvl(1'b0, 1'b1);
        chk("neg on entering", 16'h0001, {15'h0000, neg});
        step(4 * PER);
        chk("crest zero flag", 16'h0000, {15'h0000, unsup});
        hold(1'b0, 1'b1);
        wr_mid(16'h000A);
        until_lvl(1'b0, 1'b0);
        until_lvl(1'b1, 1'b0);
        chk("pos on leaving", 16'h0001, {15'h0000, pos});
        $display("t_zero done");
    endtask : t_zero
    task automatic t_extremes;
        flag_case(cpd_pkg::CPD_MODE_TROUGH, 1'b0, 16'h0000, 1'b0);
        hold(1'b1, 1'b0);
        flag_case(cpd_pkg::CPD_MODE_CREST, 1'b0, 16'h0014, 1'b1);
        flag_case(cpd_pkg::CPD_MODE_TROUGH, 1'b1, 16'h0014, 1'b1);
        flag_case(cpd_pkg::CPD_MODE_BOTH, 1'b1, 16'h0000, 1'b1);
        chk("stage fault", 16'h0000, {15'h0000, fault});
        $display("t_extremes done");
    endtask : t_extremes
    task automatic give_verdict;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : give_verdict
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        step(2);
        reset_n = 1'b1;
        chk("idle phases", 16'h0000, {14'h0000, pos, neg});
        t_write;
        t_zero;
        t_extremes;
        give_verdict;
    end
    // Tests need about 1000 cycles
    initial begin
        repeat (20000) @(posedge sys_clk);
        mismatches++;
        give_verdict;
    end
endmodule : cpd_top_bench
bind cpd_top cpd_chk #(.CNT_W(CNT_W)) cpd_chk_i (.sys_clk, .reset_n, .run_en, .start_at_crest,
    .transfer_timing_select, .period_register, .dead_time, .buf_wr, .buf_wdata, .pos_phase_q,
    .neg_phase_q, .duty_compare_register_q, .duty_temporary_register_q, .count_q, .in_window_q,
    .extreme_unsupported_q);

// File: hdl/cpd_phase.sv
`timescale 1ns/1ps
module cpd_phase (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic load,
    input wire logic load_val,
    input wire logic win_now,
    input wire cpd_pkg::cpd_evt_t evt,
    output logic level_q
);

    logic block_q;

    ////////////////////////////////////////////////////////////////////////////
    // Phase level from on and off requests
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            level_q <= 1'b0;
        end else if (load) begin
            level_q <= load_val;
        end else if (evt.on_evt && evt.off_evt) begin
            level_q <= level_q;
        end else if (evt.off_evt) begin
            level_q <= 1'b0;
        end else if (evt.on_evt && !block_q) begin
            level_q <= 1'b1;
        end
    end

    // Off seen inside a window masks later on requests until it closes
    always_ff @(posedge sys_clk) begin
        if (!reset_n || load) begin
            block_q <= 1'b0;
        end else if (!win_now) begin
            block_q <= 1'b0;
        end else if (evt.off_evt && !evt.on_evt) begin
            block_q <= 1'b1;
        end
    end

endmodule : cpd_phase

// File: hdl/cpd_pkg.sv
package cpd_pkg;

    // Default width of counter, period, dead time and duty values
    localparam int CNT_W = 16;
    // Counter width limits the logic can serve
    localparam int CNT_W_MIN = 4;
    localparam int CNT_W_MAX = 32;
    // Reset contents of the duty buffer, temporary and compare registers
    localparam logic [31:0] DUTY_RST = 32'h0000_0000;
    // Gap down-counter value that ends a dead-time gap
    localparam logic [31:0] GAP_DONE = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////
    // Transfer timing of the temporary register into the compare register
    typedef enum logic [1:0] {
        CPD_MODE_CREST = 2'b01,  // Mode 1: at the crest
        CPD_MODE_TROUGH = 2'b10, // Mode 2: at the trough
        CPD_MODE_BOTH = 2'b11    // Mode 3: at crest and trough
    } cpd_mode_t;

    // Phase that the output stage is allowed to drive
    typedef enum logic [1:0] {
        CPD_DRV_OFF = 2'b00,
        CPD_DRV_POS = 2'b01,
        CPD_DRV_NEG = 2'b10
    } cpd_drv_t;

    // Turn-on and turn-off requests for one phase in one cycle
    typedef struct packed {
        logic on_evt;
        logic off_evt;
    } cpd_evt_t;

endpackage : cpd_pkg

// File: hdl/cpd_top.sv
`timescale 1ns/1ps
// How it works
// - Compare equal to period gives 0%: positive stays off, negative stays on.
// - Compare loaded with zero at a trough start gives 100%: positive stays on, negative stays off.
// - Mode 2 transfers at trough only, mode 3 at crest and trough.
// - Extreme duties only in the listed mode and start combinations.
// - Simultaneous on and off matches leave the phase unchanged.
// - An off match inside a window blocks later on matches there.
// - Entering 0% at crest: positive off first, negative on later.
// - Leaving 0%: negative off first, then positive on.
// - Waveform in a window is the same whether or not the buffer is written in it.
// - Mode 3 allows 0% output at the counter crests.
// - Writes outside windows reach temporary at once, inside at window end.
// - At end of the selected window, temporary goes to compare.
module cpd_top #(
    parameter int CNT_W = cpd_pkg::CNT_W
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic run_en,
    input wire logic start_at_crest,
    input wire cpd_pkg::cpd_mode_t transfer_timing_select,
    input wire logic [CNT_W-1:0] period_register,
    input wire logic [CNT_W-1:0] dead_time,
    input wire logic buf_wr,
    input wire logic [CNT_W-1:0] buf_wdata,
    output logic pos_phase_q,
    output logic neg_phase_q,
    output logic [CNT_W-1:0] duty_compare_register_q,
    output logic [CNT_W-1:0] duty_temporary_register_q,
    output logic [CNT_W-1:0] count_q,
    output logic in_window_q,
    output logic extreme_unsupported_q
);

    localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
    localparam logic [CNT_W-1:0] CNT_ZERO = CNT_W'(0);
    localparam logic [CNT_W-1:0] DUTY_RST = cpd_pkg::DUTY_RST[CNT_W-1:0];
    localparam logic [CNT_W-1:0] GAP_DONE = cpd_pkg::GAP_DONE[CNT_W-1:0];

    // Widths outside this range break the window and gap arithmetic
    if (CNT_W < cpd_pkg::CNT_W_MIN || CNT_W > cpd_pkg::CNT_W_MAX) begin : g_bad_width
        $error("cpd_top: CNT_W out of range");
    end

    logic dir_up_q;
    logic run_q;
    logic [CNT_W-1:0] duty_buffer_register_q;
    logic pend_q;
    logic crest_prev_q;
    logic trough_prev_q;
    logic [CNT_W-1:0] gap_q;
    logic [CNT_W-1:0] gap_d;
    cpd_pkg::cpd_drv_t drv_q;
    cpd_pkg::cpd_drv_t drv_d;
    cpd_pkg::cpd_drv_t req;
    logic crest_win;
    logic trough_win;
    logic win_now;
    logic crest_end;
    logic trough_end;
    logic xfer_now;
    logic turn;
    logic match;
    logic load;
    logic pos_init;
    logic pos_lvl;
    logic neg_lvl;
    logic [CNT_W-1:0] temp_d;
    cpd_pkg::cpd_evt_t pos_evt;
    cpd_pkg::cpd_evt_t neg_evt;

    ////////////////////////////////////////////////////////////////////////////
    // Triangle counter; preset to the chosen start point while stopped
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            count_q <= CNT_ZERO;
            dir_up_q <= 1'b1;
        end else if (!run_en) begin
            count_q <= start_at_crest ? period_register : CNT_ZERO;
            dir_up_q <= !start_at_crest;
        end else if (dir_up_q) begin
            if (count_q >= period_register) begin
                dir_up_q <= 1'b0;
                count_q <= count_q - CNT_ONE;
            end else begin
                count_q <= count_q + CNT_ONE;
            end
        end else begin
            if (count_q == CNT_ZERO) begin
                dir_up_q <= 1'b1;
                count_q <= count_q + CNT_ONE;
            end else begin
                count_q <= count_q - CNT_ONE;
            end
        end
    end

    // Run edge reloads phase levels; held one cycle behind run_en
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            run_q <= 1'b0;
        end else begin
            run_q <= run_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Compare windows around crest and trough, each one dead time wide
    assign crest_win = run_en && (count_q >= period_register - dead_time);
    assign trough_win = run_en && (count_q <= dead_time);
    assign win_now = crest_win || trough_win;
    assign crest_end = crest_prev_q && !crest_win;
    assign trough_end = trough_prev_q && !trough_win;
    assign turn = (count_q == period_register) || (count_q == CNT_ZERO);
    assign load = !run_q;

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            crest_prev_q <= 1'b0;
            trough_prev_q <= 1'b0;
            in_window_q <= 1'b0;
        end else begin
            crest_prev_q <= crest_win;
            trough_prev_q <= trough_win;
            in_window_q <= win_now;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Buffer, temporary and compare chain
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            duty_buffer_register_q <= DUTY_RST;
        end else if (buf_wr) begin
            duty_buffer_register_q <= buf_wdata;
        end
    end

    // A write landing on the window's last cycle is taken, not dropped
    always_comb begin
        temp_d = duty_temporary_register_q;
        if (buf_wr && !win_now) begin
            temp_d = buf_wdata;
        end else if (pend_q && !win_now) begin
            temp_d = duty_buffer_register_q;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            duty_temporary_register_q <= DUTY_RST;
            pend_q <= 1'b0;
        end else begin
            duty_temporary_register_q <= temp_d;
            pend_q <= buf_wr ? win_now : (pend_q && win_now);
        end
    end

    // Mode picks which window end moves temporary into compare
    always_comb begin
        unique case (transfer_timing_select)
            cpd_pkg::CPD_MODE_CREST: xfer_now = crest_end;
            cpd_pkg::CPD_MODE_TROUGH: xfer_now = trough_end;
            cpd_pkg::CPD_MODE_BOTH: xfer_now = crest_end || trough_end;
            default: xfer_now = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            duty_compare_register_q <= DUTY_RST;
        end else if (xfer_now || !run_en) begin
            duty_compare_register_q <= temp_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Match events: compare always, temporary only inside a window.
    // At the turning points a match is both on and off, so a compare of
    // period or zero holds the phases: 0% and 100% fall out, with only the start level in pos_init special-cased.
    assign match = (count_q == duty_compare_register_q)
        || (win_now && count_q == duty_temporary_register_q);
    assign pos_evt.off_evt = match && (dir_up_q || turn);
    assign pos_evt.on_evt = match && (!dir_up_q || turn);
    assign neg_evt.on_evt = pos_evt.off_evt;
    assign neg_evt.off_evt = pos_evt.on_evt;
    assign pos_init = !start_at_crest && (duty_compare_register_q != period_register);

    cpd_phase u_pos (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .load(load),
        .load_val(pos_init),
        .win_now(win_now),
        .evt(pos_evt),
        .level_q(pos_lvl)
    );

    cpd_phase u_neg (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .load(load),
        .load_val(!pos_init),
        .win_now(win_now),
        .evt(neg_evt),
        .level_q(neg_lvl)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Dead-time sequencer: drops the driven phase, waits, then drives the
    // other. Positive wins if both levels are ever requested at once.
    always_comb begin
        if (!run_q) begin
            req = cpd_pkg::CPD_DRV_OFF;
        end else if (pos_lvl) begin
            req = cpd_pkg::CPD_DRV_POS;
        end else if (neg_lvl) begin
            req = cpd_pkg::CPD_DRV_NEG;
        end else begin
            req = cpd_pkg::CPD_DRV_OFF;
        end
    end

    always_comb begin
        drv_d = drv_q;
        gap_d = gap_q;
        unique case (drv_q)
            cpd_pkg::CPD_DRV_OFF: begin
                if (gap_q != GAP_DONE) begin
                    gap_d = gap_q - CNT_ONE;
                end else begin
                    drv_d = req;
                end
            end
            cpd_pkg::CPD_DRV_POS, cpd_pkg::CPD_DRV_NEG: begin
                if (req != drv_q) begin
                    drv_d = cpd_pkg::CPD_DRV_OFF;
                    gap_d = dead_time;
                end
            end
            default: begin
                drv_d = cpd_pkg::CPD_DRV_OFF;
                gap_d = dead_time;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            drv_q <= cpd_pkg::CPD_DRV_OFF;
            gap_q <= GAP_DONE;
            pos_phase_q <= 1'b0;
            neg_phase_q <= 1'b0;
        end else begin
            drv_q <= drv_d;
            gap_q <= gap_d;
            pos_phase_q <= (drv_d == cpd_pkg::CPD_DRV_POS);
            neg_phase_q <= (drv_d == cpd_pkg::CPD_DRV_NEG);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Flags an extreme duty the mode and start point cannot produce
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            extreme_unsupported_q <= 1'b0;
        end else begin
            extreme_unsupported_q <= run_en && (
                ((duty_compare_register_q == period_register) &&
                 ((transfer_timing_select == cpd_pkg::CPD_MODE_CREST && !start_at_crest) ||
                  (transfer_timing_select == cpd_pkg::CPD_MODE_TROUGH && start_at_crest)))
                || ((duty_compare_register_q == CNT_ZERO) &&
                 (start_at_crest || transfer_timing_select == cpd_pkg::CPD_MODE_CREST)));
        end
    end

endmodule : cpd_top
